//--- src/sbpfm_pkg.sv
package sbpfm_pkg;

    // Bridge operating mode as chosen by the serial engine configuration
    typedef enum logic [2:0] {
        SBPFM_OFF      = 3'b000,
        SBPFM_M_SINGLE = 3'b001,
        SBPFM_M_DUAL   = 3'b010,
        SBPFM_M_QUAD   = 3'b011,
        SBPFM_S_SINGLE = 3'b100,
        SBPFM_TWO_WIRE = 3'b101
    } sbpfm_mode_t;

    // Role of one general pin; code 2'b11 behaves as plain I/O
    typedef enum logic [1:0] {
        SBPFM_FN_GPIO  = 2'b00,
        SBPFM_FN_ALT_A = 2'b01,
        SBPFM_FN_ALT_B = 2'b10
    } sbpfm_func_t;

    // Positions of the pin inputs inside the synchroniser vector
    localparam int SBPFM_SYNC_W  = 14;
    localparam int IX_SCK        = 0;
    localparam int IX_MISO       = 1;
    localparam int IX_MOSI       = 2;
    localparam int IX_QD2        = 3;
    localparam int IX_QD3        = 4;
    localparam int IX_GP0        = 5;
    localparam int IX_GP1        = 6;
    localparam int IX_GP2        = 7;
    localparam int IX_GP3        = 8;
    localparam int IX_SLV_SEL_N  = 9;
    localparam int IX_CHIP_RST_N = 10;
    localparam int IX_TEST_RST_N = 11;
    localparam int IX_CFG0       = 12;
    localparam int IX_CFG1       = 13;

    // Reset values
    localparam logic [SBPFM_SYNC_W-1:0] SYNC_RST = 14'h0000;
    localparam logic        CS_IDLE       = 1'b1;
    localparam logic        BUS_IDLE      = 1'b1;
    localparam logic        SS_IDLE_N     = 1'b1;
    localparam logic        PIN_RST       = 1'b0;
    localparam logic [3:0]  NIB_RST       = 4'h0;
    localparam logic [1:0]  CHIP_MODE_RST = 2'h0;
    localparam logic        CHARGER_RST   = 1'b0;

    function automatic logic is_master(input sbpfm_mode_t m);
        is_master = (m == SBPFM_M_SINGLE) || (m == SBPFM_M_DUAL) ||
                    (m == SBPFM_M_QUAD);
    endfunction

endpackage

//--- src/sbpfm_sync.sv
`timescale 1ns/100ps
module sbpfm_sync
    import sbpfm_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // The first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta <= SYNC_RST[W-1:0];
            q    <= SYNC_RST[W-1:0];
        end
        else if (clk_en)
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

//--- src/sbpfm_top.sv
// How it works
// - The clock pin is driven in master modes and only sampled in slave mode.
// - MISO takes receive data in master single, data bit 1 in dual or quad, and transmit data in slave mode.
// - MOSI carries transmit data in master single, data bit 0 in dual or quad, and receive data in slave mode.
// - The two extra quad lines carry data bits 2 and 3 only in quad master mode.
// - General pin 0 is plain I/O unless switched to chip select 1 or the two-wire clock.
// - General pin 1 is plain I/O unless switched to chip select 2 or the two-wire data line.
// - General pin 2 is plain I/O unless switched to chip select 3 or the suspend indicator.
// - General pin 3 is plain I/O unless switched to a wakeup input or an interrupt input.
// - The dedicated chip select 0 output selects a peripheral in master mode and idles high otherwise.
// - The slave select pin reaches the engine only in slave mode.
// - A low chip reset pin resets the whole block except the input synchroniser, which only the system reset clears.
// - The two configuration select pins are sampled as a two-bit chip mode code.
// - The charger flag is asserted on a charging port with selectable polarity.
`timescale 1ns/100ps
module sbpfm_top
    import sbpfm_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CLK_EN,
    input  wire logic        CHIP_RESET_N,
    input  wire logic        TEST_MODE_RESET_N,
    input  wire logic        CHIP_CONFIG_SEL_0,
    input  wire logic        CHIP_CONFIG_SEL_1,
    input  wire sbpfm_mode_t SPI_MODE,
    input  wire sbpfm_func_t GP0_FUNC,
    input  wire sbpfm_func_t GP1_FUNC,
    input  wire sbpfm_func_t GP2_FUNC,
    input  wire sbpfm_func_t GP3_FUNC,
    input  wire logic        ENG_SCK_OUT,
    input  wire logic [3:0]  ENG_DOUT,
    input  wire logic [3:0]  ENG_DOE,
    input  wire logic [3:0]  ENG_CS_N,
    input  wire logic        TWI_SCL_OUT,
    input  wire logic        TWI_SDA_OUT,
    input  wire logic [3:0]  GPIO_OUT,
    input  wire logic [3:0]  GPIO_OE,
    input  wire logic        SUSPEND_INDICATOR,
    input  wire logic        CHARGER_DETECTED,
    input  wire logic        CHARGER_ACTIVE_HIGH,
    input  wire logic        SCK_I,
    output logic             SCK_O,
    output logic             SCK_OE,
    input  wire logic        MISO_I,
    output logic             MISO_O,
    output logic             MISO_OE,
    input  wire logic        MOSI_I,
    output logic             MOSI_O,
    output logic             MOSI_OE,
    input  wire logic        QUAD_DATA_LINE_2_I,
    output logic             QUAD_DATA_LINE_2_O,
    output logic             QUAD_DATA_LINE_2_OE,
    input  wire logic        QUAD_DATA_LINE_3_I,
    output logic             QUAD_DATA_LINE_3_O,
    output logic             QUAD_DATA_LINE_3_OE,
    input  wire logic        GENERAL_PIN_0_I,
    output logic             GENERAL_PIN_0_O,
    output logic             GENERAL_PIN_0_OE,
    input  wire logic        GENERAL_PIN_1_I,
    output logic             GENERAL_PIN_1_O,
    output logic             GENERAL_PIN_1_OE,
    input  wire logic        GENERAL_PIN_2_I,
    output logic             GENERAL_PIN_2_O,
    output logic             GENERAL_PIN_2_OE,
    input  wire logic        GENERAL_PIN_3_I,
    output logic             GENERAL_PIN_3_O,
    output logic             GENERAL_PIN_3_OE,
    input  wire logic        SLAVE_SEL_N_I,
    output logic             CHIP_SELECT_OUT_0,
    output logic             CHARGER_PORT_FLAG,
    output logic [1:0]       CHIP_MODE,
    output logic             ENG_SCK_IN,
    output logic [3:0]       ENG_DIN,
    output logic             ENG_SS_N,
    output logic             TWI_SCL_IN,
    output logic             TWI_SDA_IN,
    output logic [3:0]       GPIO_IN,
    output logic             WAKEUP_REQ,
    output logic             EXT_INTERRUPT
);

    logic [SBPFM_SYNC_W-1:0] pin_raw;
    logic [SBPFM_SYNC_W-1:0] pin_s;
    logic                    rst;
    logic                    strap_done;
    sbpfm_mode_t             mode_q;
    sbpfm_func_t             func_q [4];
    logic [3:0]              gp_s;
    logic [3:0]              gp_o;
    logic [3:0]              gp_oe;
    logic [3:0]              next_gp_o;
    logic [3:0]              next_gp_oe;
    logic                    next_sck_o;
    logic                    next_sck_oe;
    logic                    next_sck_in;
    logic                    next_miso_o;
    logic                    next_miso_oe;
    logic                    next_mosi_o;
    logic                    next_mosi_oe;
    logic [3:2]              next_qd_o;
    logic [3:2]              next_qd_oe;
    logic [3:0]              next_din;
    logic                    next_cs0;
    logic                    master;

    assign pin_raw = {CHIP_CONFIG_SEL_1, CHIP_CONFIG_SEL_0, TEST_MODE_RESET_N,
                      CHIP_RESET_N, SLAVE_SEL_N_I, GENERAL_PIN_3_I,
                      GENERAL_PIN_2_I, GENERAL_PIN_1_I, GENERAL_PIN_0_I,
                      QUAD_DATA_LINE_3_I, QUAD_DATA_LINE_2_I, MOSI_I,
                      MISO_I, SCK_I};

    sbpfm_sync #(.W(SBPFM_SYNC_W)) u_sync (
        .clk     (CLK),
        .sys_rst (SYS_RST),
        .clk_en  (CLK_EN),
        .d       (pin_raw),
        .q       (pin_s)
    );

    assign gp_s = pin_s[IX_GP3:IX_GP0];
    assign master = is_master(mode_q);

    // chip reset pin
    // Test reset is honoured too, so a board that forgets the tie-off
    // holds the block quiet instead of running half configured.
    // reserved reset
    assign rst = SYS_RST || !pin_s[IX_CHIP_RST_N] || !pin_s[IX_TEST_RST_N];

    // strap capture
    // Sampled once on the first enabled edge after reset releases.
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            strap_done <= 1'b0;
            CHIP_MODE  <= CHIP_MODE_RST;
        end
        else if (CLK_EN && !strap_done)
        begin
            strap_done <= 1'b1;
            CHIP_MODE  <= {pin_s[IX_CFG1], pin_s[IX_CFG0]};
        end
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            mode_q <= SBPFM_OFF;
            for (int i = 0; i < 4; i++)
                func_q[i] <= SBPFM_FN_GPIO;
        end
        else if (CLK_EN)
        begin
            mode_q    <= SPI_MODE;
            func_q[0] <= GP0_FUNC;
            func_q[1] <= GP1_FUNC;
            func_q[2] <= GP2_FUNC;
            func_q[3] <= GP3_FUNC;
        end
    end

    always_comb
    begin
        next_sck_o   = PIN_RST;
        next_sck_oe  = 1'b0;
        next_sck_in  = PIN_RST;
        next_miso_o  = PIN_RST;
        next_miso_oe = 1'b0;
        next_mosi_o  = PIN_RST;
        next_mosi_oe = 1'b0;
        next_qd_o    = 2'h0;
        next_qd_oe   = 2'h0;
        next_din     = NIB_RST;
        next_cs0     = CS_IDLE;
        if (master)
        begin
            next_sck_o  = ENG_SCK_OUT;
            next_sck_oe = 1'b1;
            next_cs0    = ENG_CS_N[0];
        end
        case (mode_q)
            SBPFM_M_SINGLE:
            begin
                next_mosi_o  = ENG_DOUT[0];
                next_mosi_oe = 1'b1;
                next_din[0]  = pin_s[IX_MISO];
            end
            SBPFM_M_DUAL, SBPFM_M_QUAD:
            begin
                next_mosi_o    = ENG_DOUT[0];
                next_mosi_oe   = ENG_DOE[0];
                next_miso_o    = ENG_DOUT[1];
                next_miso_oe   = ENG_DOE[1];
                next_din[1:0]  = {pin_s[IX_MISO], pin_s[IX_MOSI]};
                if (mode_q == SBPFM_M_QUAD)
                begin
                    next_qd_o     = ENG_DOUT[3:2];
                    next_qd_oe    = ENG_DOE[3:2];
                    next_din[3:2] = {pin_s[IX_QD3], pin_s[IX_QD2]};
                end
            end
            SBPFM_S_SINGLE:
            begin
                next_sck_in  = pin_s[IX_SCK];
                next_din[0]  = pin_s[IX_MOSI];
                // MISO as slave output
                // Driven only while selected so other slaves can share it
                next_miso_o  = ENG_DOUT[0];
                next_miso_oe = !pin_s[IX_SLV_SEL_N];
            end
            default:
            begin
            end
        endcase
    end

    always_comb
    begin
        next_gp_o  = GPIO_OUT;
        next_gp_oe = GPIO_OE;
        case (func_q[0])
            SBPFM_FN_ALT_A:
            begin
                next_gp_o[0]  = master ? ENG_CS_N[1] : CS_IDLE;
                next_gp_oe[0] = 1'b1;
            end
            SBPFM_FN_ALT_B:
            begin
                next_gp_o[0]  = 1'b0;
                next_gp_oe[0] = !TWI_SCL_OUT;
            end
            default:
            begin
            end
        endcase
        case (func_q[1])
            SBPFM_FN_ALT_A:
            begin
                next_gp_o[1]  = master ? ENG_CS_N[2] : CS_IDLE;
                next_gp_oe[1] = 1'b1;
            end
            SBPFM_FN_ALT_B:
            begin
                next_gp_o[1]  = 1'b0;
                next_gp_oe[1] = !TWI_SDA_OUT;
            end
            default:
            begin
            end
        endcase
        case (func_q[2])
            SBPFM_FN_ALT_A:
            begin
                next_gp_o[2]  = master ? ENG_CS_N[3] : CS_IDLE;
                next_gp_oe[2] = 1'b1;
            end
            SBPFM_FN_ALT_B:
            begin
                next_gp_o[2]  = SUSPEND_INDICATOR;
                next_gp_oe[2] = 1'b1;
            end
            default:
            begin
            end
        endcase
        if (func_q[3] == SBPFM_FN_ALT_A || func_q[3] == SBPFM_FN_ALT_B)
        begin
            next_gp_o[3]  = 1'b0;
            next_gp_oe[3] = 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            SCK_O               <= PIN_RST;
            SCK_OE              <= 1'b0;
            MISO_O              <= PIN_RST;
            MISO_OE             <= 1'b0;
            MOSI_O              <= PIN_RST;
            MOSI_OE             <= 1'b0;
            QUAD_DATA_LINE_2_O  <= PIN_RST;
            QUAD_DATA_LINE_2_OE <= 1'b0;
            QUAD_DATA_LINE_3_O  <= PIN_RST;
            QUAD_DATA_LINE_3_OE <= 1'b0;
            CHIP_SELECT_OUT_0   <= CS_IDLE;
            gp_o                <= NIB_RST;
            gp_oe               <= NIB_RST;
        end
        else if (CLK_EN)
        begin
            SCK_O               <= next_sck_o;
            SCK_OE              <= next_sck_oe;
            MISO_O              <= next_miso_o;
            MISO_OE             <= next_miso_oe;
            MOSI_O              <= next_mosi_o;
            MOSI_OE             <= next_mosi_oe;
            QUAD_DATA_LINE_2_O  <= next_qd_o[2];
            QUAD_DATA_LINE_2_OE <= next_qd_oe[2];
            QUAD_DATA_LINE_3_O  <= next_qd_o[3];
            QUAD_DATA_LINE_3_OE <= next_qd_oe[3];
            CHIP_SELECT_OUT_0   <= next_cs0;
            gp_o                <= next_gp_o;
            gp_oe               <= next_gp_oe;
        end
    end

    assign GENERAL_PIN_0_O  = gp_o[0];
    assign GENERAL_PIN_0_OE = gp_oe[0];
    assign GENERAL_PIN_1_O  = gp_o[1];
    assign GENERAL_PIN_1_OE = gp_oe[1];
    assign GENERAL_PIN_2_O  = gp_o[2];
    assign GENERAL_PIN_2_OE = gp_oe[2];
    assign GENERAL_PIN_3_O  = gp_o[3];
    assign GENERAL_PIN_3_OE = gp_oe[3];

    // Engine-facing inputs; an idle two-wire line reads high
    always_ff @(posedge CLK)
    begin
        if (rst)
        begin
            ENG_SCK_IN        <= PIN_RST;
            ENG_DIN           <= NIB_RST;
            ENG_SS_N          <= SS_IDLE_N;
            TWI_SCL_IN        <= BUS_IDLE;
            TWI_SDA_IN        <= BUS_IDLE;
            GPIO_IN           <= NIB_RST;
            WAKEUP_REQ        <= 1'b0;
            EXT_INTERRUPT     <= 1'b0;
            CHARGER_PORT_FLAG <= CHARGER_RST;
        end
        else if (CLK_EN)
        begin
            ENG_SCK_IN    <= next_sck_in;
            ENG_DIN       <= next_din;
            ENG_SS_N      <= (mode_q == SBPFM_S_SINGLE) ?
                             pin_s[IX_SLV_SEL_N] : SS_IDLE_N;
            TWI_SCL_IN    <= (func_q[0] == SBPFM_FN_ALT_B) ? gp_s[0] : BUS_IDLE;
            TWI_SDA_IN    <= (func_q[1] == SBPFM_FN_ALT_B) ? gp_s[1] : BUS_IDLE;
            GPIO_IN       <= gp_s;
            WAKEUP_REQ    <= (func_q[3] == SBPFM_FN_ALT_A) && gp_s[3];
            EXT_INTERRUPT <= (func_q[3] == SBPFM_FN_ALT_B) && gp_s[3];
            CHARGER_PORT_FLAG <= CHARGER_DETECTED ? CHARGER_ACTIVE_HIGH
                                                  : !CHARGER_ACTIVE_HIGH;
        end
    end

    chk_sck_master_drive: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && master) |=> (SCK_OE && SCK_O == $past(ENG_SCK_OUT)))
        else $error("clock pin not driven as master");

    chk_sck_slave_input: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && mode_q == SBPFM_S_SINGLE) |=> !SCK_OE)
        else $error("clock pin driven in slave mode");

    chk_miso_slave_out: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && mode_q == SBPFM_S_SINGLE && !pin_s[IX_SLV_SEL_N])
        |=> (MISO_OE && MISO_O == $past(ENG_DOUT[0])))
        else $error("MISO not carrying slave output");

    chk_mosi_single_out: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && mode_q == SBPFM_M_SINGLE)
        |=> (MOSI_OE && MOSI_O == $past(ENG_DOUT[0]) && !MISO_OE))
        else $error("MOSI not carrying master output");

    chk_quad_lines_idle: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && mode_q != SBPFM_M_QUAD)
        |=> (!QUAD_DATA_LINE_2_OE && !QUAD_DATA_LINE_3_OE))
        else $error("quad lines driven outside quad mode");

    chk_gp0_plain_io: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && func_q[0] == SBPFM_FN_GPIO)
        |=> (GENERAL_PIN_0_OE == $past(GPIO_OE[0])))
        else $error("general pin 0 not following plain I/O");

    chk_gp1_open_drain: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && func_q[1] == SBPFM_FN_ALT_B)
        |=> (!GENERAL_PIN_1_O && GENERAL_PIN_1_OE == !$past(TWI_SDA_OUT)))
        else $error("general pin 1 not an open-drain data line");

    chk_gp2_suspend_out: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && func_q[2] == SBPFM_FN_ALT_B)
        |=> (GENERAL_PIN_2_OE && GENERAL_PIN_2_O == $past(SUSPEND_INDICATOR)))
        else $error("suspend indicator not on general pin 2");

    chk_cs0_idle_high: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && !master) |=> CHIP_SELECT_OUT_0)
        else $error("chip select 0 active outside master mode");

    chk_ss_gated_off: assert property (@(posedge CLK) disable iff (rst)
        (CLK_EN && mode_q != SBPFM_S_SINGLE) |=> ENG_SS_N)
        else $error("slave select passed outside slave mode");

    chk_reset_to_gpio: assert property (@(posedge CLK)
        rst |=> (func_q[0] == SBPFM_FN_GPIO && func_q[1] == SBPFM_FN_GPIO &&
                 func_q[2] == SBPFM_FN_GPIO && func_q[3] == SBPFM_FN_GPIO &&
                 mode_q == SBPFM_OFF))
        else $error("roles not restored by reset");

    chk_strap_stable: assert property (@(posedge CLK) disable iff (rst)
        (strap_done && $past(strap_done)) |-> $stable(CHIP_MODE))
        else $error("chip mode changed after capture");

    chk_charger_polarity: assert property (@(posedge CLK) disable iff (rst)
        CLK_EN |=> (CHARGER_PORT_FLAG ==
                    ($past(CHARGER_DETECTED) ~^ $past(CHARGER_ACTIVE_HIGH))))
        else $error("charger flag polarity wrong");

endmodule

//--- verification/sbpfm_periph.sv
`timescale 1ns/100ps
module sbpfm_periph
    import sbpfm_pkg::*;
(
    input  wire logic        [8:0] pin_o,
    input  wire logic        [8:0] pin_oe,
    input  wire logic        [8:0] ext,
    input  wire sbpfm_mode_t       mode,
    input  wire logic              ss_req,
    output logic             [8:0] pin_i,
    output logic                   ss_n
);
    always_comb ss_n = (mode inside {SBPFM_M_SINGLE, SBPFM_M_DUAL,
                                     SBPFM_M_QUAD}) | ss_req;
    // Far side lets go of a line the bridge drives; released lines random
    always_comb pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule

//--- verification/testbench.sv
`timescale 1ns/100ps
module testbench
    import sbpfm_pkg::*;
;
    typedef struct {string nm; logic [35:0] e; logic [35:0] k;} sbpfm_note_t;
    logic        clk = 1'h0, rst = 1'h1, crn = 1'h1, en = 1'h1;
    sbpfm_mode_t md = SBPFM_OFF;
    sbpfm_func_t gf [4] = '{default: SBPFM_FN_GPIO};
    logic        sko, scl, sda, sus, chg, pol, ssr;
    logic [3:0]  dout, doe, csn, go, goe;
    logic [8:0]  ext;
    logic [35:0] fe, fk;
    logic [1:0]  st = 2'h1, stc = 2'h1;
    wire  [8:0]  po, poe, pi;
    wire  [3:0]  din, gin;
    wire  [1:0]  cm;
    wire         cs0, cpf, sckin, ssn, sclin, sdain, wk, ei, ss_n;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0;
    sbpfm_note_t q [$];
    sbpfm_note_t n;
    wire  [35:0] obs = {po, poe, cs0, cpf, cm, sckin, din, ssn, sclin,
                        sdain, gin, wk, ei};

    sbpfm_top sbpfm_top_i (
        .CLK(clk), .SYS_RST(rst), .CLK_EN(en), .CHIP_RESET_N(crn),
        .TEST_MODE_RESET_N(1'h1), .CHIP_CONFIG_SEL_0(st[0]),
        .CHIP_CONFIG_SEL_1(st[1]), .SPI_MODE(md), .GP0_FUNC(gf[0]),
        .GP1_FUNC(gf[1]), .GP2_FUNC(gf[2]), .GP3_FUNC(gf[3]),
        .ENG_SCK_OUT(sko), .ENG_DOUT(dout), .ENG_DOE(doe), .ENG_CS_N(csn),
        .TWI_SCL_OUT(scl), .TWI_SDA_OUT(sda), .GPIO_OUT(go), .GPIO_OE(goe),
        .SUSPEND_INDICATOR(sus), .CHARGER_DETECTED(chg),
        .CHARGER_ACTIVE_HIGH(pol), .SCK_I(pi[0]), .SCK_O(po[0]),
        .SCK_OE(poe[0]), .MISO_I(pi[1]), .MISO_O(po[1]), .MISO_OE(poe[1]),
        .MOSI_I(pi[2]), .MOSI_O(po[2]), .MOSI_OE(poe[2]),
        .QUAD_DATA_LINE_2_I(pi[3]), .QUAD_DATA_LINE_2_O(po[3]),
        .QUAD_DATA_LINE_2_OE(poe[3]), .QUAD_DATA_LINE_3_I(pi[4]),
        .QUAD_DATA_LINE_3_O(po[4]), .QUAD_DATA_LINE_3_OE(poe[4]),
        .GENERAL_PIN_0_I(pi[5]), .GENERAL_PIN_0_O(po[5]),
        .GENERAL_PIN_0_OE(poe[5]), .GENERAL_PIN_1_I(pi[6]),
        .GENERAL_PIN_1_O(po[6]), .GENERAL_PIN_1_OE(poe[6]),
        .GENERAL_PIN_2_I(pi[7]), .GENERAL_PIN_2_O(po[7]),
        .GENERAL_PIN_2_OE(poe[7]), .GENERAL_PIN_3_I(pi[8]),
        .GENERAL_PIN_3_O(po[8]), .GENERAL_PIN_3_OE(poe[8]),
        .SLAVE_SEL_N_I(ss_n), .CHIP_SELECT_OUT_0(cs0),
        .CHARGER_PORT_FLAG(cpf), .CHIP_MODE(cm), .ENG_SCK_IN(sckin),
        .ENG_DIN(din), .ENG_SS_N(ssn), .TWI_SCL_IN(sclin),
        .TWI_SDA_IN(sdain), .GPIO_IN(gin), .WAKEUP_REQ(wk),
        .EXT_INTERRUPT(ei)
    );

    sbpfm_periph sbpfm_periph_i (
        .pin_o(po), .pin_oe(poe), .ext(ext), .mode(md), .ss_req(ssr),
        .pin_i(pi), .ss_n(ss_n)
    );

    initial forever #12.5 clk = ~clk;

    // Pin drive values only matter while the pin is driven, hence the mask
    function automatic void model(output logic [35:0] e,
                                  output logic [35:0] k);
        logic [8:0] o, oe, w;
        logic [3:0] di, c;
        logic       ms, sl, sn;
        ms = md inside {SBPFM_M_SINGLE, SBPFM_M_DUAL, SBPFM_M_QUAD};
        sl = md == SBPFM_S_SINGLE;
        sn = ms | ssr;
        c = {1'h1, csn[3:1]};
        oe[0] = ms;
        o[0] = sko;
        oe[2] = md == SBPFM_M_SINGLE || (ms && doe[0]);
        o[2] = dout[0];
        oe[1] = (ms && md != SBPFM_M_SINGLE && doe[1]) || (sl && !sn);
        o[1] = sl ? dout[0] : dout[1];
        oe[4:3] = md == SBPFM_M_QUAD ? doe[3:2] : 2'h0;
        o[4:3] = dout[3:2];
        for (int i = 0; i < 4; i++)
            case (gf[i])
                SBPFM_FN_ALT_A: {oe[i+5], o[i+5]} = {i < 3, !ms | c[i]};
                SBPFM_FN_ALT_B: {oe[i+5], o[i+5]} =
                    i < 2 ? {!(i == 1 ? sda : scl), 1'h0} : {i == 2, sus};
                default: {oe[i+5], o[i+5]} = {goe[i], go[i]};
            endcase
        w = (oe & o) | (~oe & ext);
        di = 4'h0;
        case (md)
            SBPFM_M_SINGLE: di[0] = w[1];
            SBPFM_M_DUAL:   di[1:0] = {w[1], w[2]};
            SBPFM_M_QUAD:   di = {w[4], w[3], w[1], w[2]};
            SBPFM_S_SINGLE: di[0] = w[2];
            default: ;
        endcase
        e = {o, oe, !ms | csn[0], chg ~^ pol, stc, sl & w[0], di, !sl | sn,
             gf[0] != SBPFM_FN_ALT_B | w[5], gf[1] != SBPFM_FN_ALT_B | w[6],
             w[8:5], gf[3] == SBPFM_FN_ALT_A & w[8],
             gf[3] == SBPFM_FN_ALT_B & w[8]};
        k = {oe, 27'h7FFFFFF};
    endfunction

    task automatic push(string nm, logic [35:0] e, logic [35:0] k);
        q.push_back('{nm, e, k});
        @(negedge clk);
    endtask

    // Long settle covers reset release, mode register and input sync
    task automatic check(string nm);
        logic [35:0] e, k;
        repeat (7) @(negedge clk);
        model(e, k);
        push(nm, e, k);
    endtask

    task automatic rnd();
        logic [63:0] r;
        r = {$urandom, $urandom};
        {sko, dout, doe, csn, scl, sda, go, goe, sus, chg, pol, ext, ssr}
            = r[35:0];
    endtask

    task automatic cmp_vec(string nm, logic [35:0] e, logic [35:0] k);
        samples_checked++;
        if ((obs & k) !== (e & k))
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e & k, obs & k);
        end
    endtask

    always @(posedge clk)
    begin
        #1;
        while (q.size() > 0)
        begin
            n = q.pop_front();
            cmp_vec(n.nm, n.e, n.k);
        end
    end

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(33830));
        rnd();
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        // Every mode code, invalid ones too, with every role code
        for (int m = 0; m < 8; m++)
            for (int j = 0; j < 8; j++)
            begin
                rnd();
                md = sbpfm_mode_t'(m);
                foreach (gf[i])
                    gf[i] = sbpfm_func_t'(2'(j < 4 ? j : $urandom));
                check("mode map");
            end // cover the same map
        $display("test mode_map done");
        // Low enable: outputs hold although every input but enable, resets, mode, roles and straps moves
        model(fe, fk);
        en = 1'h0;
        rnd();
        repeat (7) @(negedge clk);
        push("frozen", fe, fk);
        en = 1'h1;
        $display("test freeze done");
        // Straps latch once; only a reset picks up a new code
        st = 2'h2;
        check("strap held");
        $display("test strap done");
        md = SBPFM_M_QUAD;
        foreach (gf[i])
            gf[i] = SBPFM_FN_ALT_B;
        crn = 1'h0;
        repeat (5) @(negedge clk);
        push("chip reset", 36'h0000201C0, {36{1'h1}});
        crn = 1'h1;
        foreach (gf[i])
            gf[i] = SBPFM_FN_GPIO;
        stc = st;
        rnd();
        check("after reset");
        $display("test reset done");
        summarize();
    end
endmodule
